// >>> core/ebshc_params.svh
`ifndef EBSHC_PARAMS_SVH
`define EBSHC_PARAMS_SVH
// machine cycle is two fast clocks: clock output toggles every fast cycle
`define EBSHC_MC_DIV 2
// ready is only looked at from this many programmed wait states upward
`define EBSHC_MIN_RDY_WAITS 3'h2
`define EBSHC_ADDR_W 6
`define EBSHC_DATA_W 16
`define EBSHC_WAIT_W 3
`endif

// >>> core/ebshc_pkg.sv
package ebshc_pkg;
  typedef enum logic [1:0] {
    ebshc_space_data,
    ebshc_space_prog,
    ebshc_space_io
  } ebshc_space_type;
endpackage

// >>> core/ebshc_sync3.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; output moves once stages two and three agree
module ebshc_sync3 (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // pin and result
  input wire logic pin_i,
  input wire logic reset_value_i,
  output logic level_o
);
  logic [2:0] stage;
  logic primed;

  // reset value comes through a clocked load after release; all stages take it too,
  // otherwise cleared stages would agree on a false level right after reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stage <= 3'h0;
      primed <= 1'b0;
      level_o <= 1'b0;
    end else if (!primed) begin
      stage <= {3{reset_value_i}};
      primed <= 1'b1;
      level_o <= reset_value_i;
    end else begin
      // first stage feeds only the second
      stage <= {stage[1:0], pin_i};
      if (stage[1] == stage[2]) begin
        level_o <= stage[2];
      end
    end
  end
endmodule

// >>> core/ebshc_bus_ctrl.sv
`timescale 1ns/1ps
`include "ebshc_params.svh"
module ebshc_bus_ctrl (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // core access request, held until done pulse
  input wire logic req_i,
  input wire ebshc_pkg::ebshc_space_type req_space_i,
  input wire logic req_write_i,
  input wire logic [`EBSHC_ADDR_W-1:0] req_addr_i,
  input wire logic [`EBSHC_DATA_W-1:0] req_wdata_i,
  input wire logic [`EBSHC_WAIT_W-1:0] wait_states_i,
  output logic done_o,
  output logic [`EBSHC_DATA_W-1:0] rdata_o,
  // pins from outside
  input wire logic ready_pin_i,
  input wire logic hold_req_n_i,
  input wire logic emulation_float_n,
  input wire logic [`EBSHC_DATA_W-1:0] data_pin_i,
  // address and data pins
  output logic [`EBSHC_ADDR_W-1:0] addr_o,
  output logic addr_oe_o,
  output logic [`EBSHC_DATA_W-1:0] data_o,
  output logic data_oe_o,
  // control pins, each group with its enable
  output logic data_space_select_n,
  output logic program_space_select_n,
  output logic io_space_select_n,
  output logic select_oe_o,
  output logic memory_access_strobe_n,
  output logic io_access_strobe_n,
  output logic strobe_oe_o,
  output logic read_write_o,
  output logic read_write_oe_o,
  output logic bus_claim_ack_n,
  output logic bus_claim_ack_oe_o,
  output logic machine_cycle_clock_out,
  output logic machine_cycle_clock_oe_o
);
  import ebshc_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic ready_s;
  logic hold_n_s;
  logic emu_n_s;

  ebshc_sync3 u_ready (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(ready_pin_i),
    .reset_value_i(1'b0),
    .level_o(ready_s)
  );
  ebshc_sync3 u_hold (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(hold_req_n_i),
    .reset_value_i(1'b1),
    .level_o(hold_n_s)
  );
  ebshc_sync3 u_emu (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(emulation_float_n),
    .reset_value_i(1'b1),
    .level_o(emu_n_s)
  );

  // ****************************************
  // machine cycle clock
  // ****************************************
  logic mc_phase;
  logic mc_tick;

  // toggles every fast cycle; rising edge marks the start of a machine cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mc_phase <= 1'b0;
    end else begin
      mc_phase <= ~mc_phase;
    end
  end
  assign mc_tick = mc_phase;

  // ****************************************
  // access sequencer
  // ****************************************
  typedef enum logic [2:0] {
    st_idle,
    st_wait,
    st_ready,
    st_finish,
    st_hold
  } ebshc_state_type;

  ebshc_state_type state;
  logic [`EBSHC_WAIT_W-1:0] wait_cnt;
  logic use_ready;
  logic writing;
  ebshc_space_type space;

  // sequencing only advances on machine cycle boundaries
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= st_idle;
      wait_cnt <= '0;
      use_ready <= 1'b0;
      writing <= 1'b0;
      space <= ebshc_space_data;
    end else if (mc_tick) begin
      unique case (state)
        st_idle: begin
          if (!hold_n_s) begin
            state <= st_hold;
          end else if (req_i) begin
            state <= st_wait;
            wait_cnt <= wait_states_i;
            use_ready <= (wait_states_i >= `EBSHC_MIN_RDY_WAITS);
            writing <= req_write_i;
            space <= req_space_i;
          end
        end
        st_wait: begin
          // ready is ignored until the software waits expire
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 3'h1;
          end else if (use_ready) begin
            state <= st_ready;
          end else begin
            state <= st_finish;
          end
        end
        st_ready: begin
          if (ready_s) begin
            state <= st_finish;
          end
        end
        st_finish: begin
          state <= st_idle;
        end
        st_hold: begin
          // hold is only entered between accesses, but a hold request floats write data at once, even mid-access
          if (hold_n_s) begin
            state <= st_idle;
          end
        end
      endcase
    end
  end

  logic active;
  assign active = (state == st_wait) || (state == st_ready) || (state == st_finish);

  // done pulse and read capture at the end of the final machine cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
      rdata_o <= '0;
    end else begin
      done_o <= mc_tick && (state == st_finish);
      if (mc_tick && (state == st_finish) && !writing) begin
        rdata_o <= data_pin_i;
      end
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  logic next_in_hold;
  assign next_in_hold = (state == st_hold);

  // selects and strobes; one space per access, strobe matched to it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_space_select_n <= 1'b1;
      program_space_select_n <= 1'b1;
      io_space_select_n <= 1'b1;
      memory_access_strobe_n <= 1'b1;
      io_access_strobe_n <= 1'b1;
      read_write_o <= 1'b1;
    end else begin
      data_space_select_n <= !(active && space == ebshc_space_data);
      program_space_select_n <= !(active && space == ebshc_space_prog);
      io_space_select_n <= !(active && space == ebshc_space_io);
      memory_access_strobe_n <= !(active && space != ebshc_space_io);
      io_access_strobe_n <= !(active && space == ebshc_space_io);
      read_write_o <= !(active && writing);
    end
  end

  // address and write data follow the access
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_o <= '0;
      data_o <= '0;
    end else if (mc_tick && state == st_idle && req_i) begin
      addr_o <= req_addr_i;
      data_o <= req_wdata_i;
    end
  end

  // output enables; emulation float overrides everything
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      select_oe_o <= 1'b0;
      strobe_oe_o <= 1'b0;
      read_write_oe_o <= 1'b0;
      addr_oe_o <= 1'b0;
      data_oe_o <= 1'b0;
      bus_claim_ack_oe_o <= 1'b0;
      machine_cycle_clock_oe_o <= 1'b0;
    end else begin
      select_oe_o <= emu_n_s && !next_in_hold;
      strobe_oe_o <= emu_n_s && !next_in_hold;
      read_write_oe_o <= emu_n_s && !next_in_hold;
      addr_oe_o <= emu_n_s && !next_in_hold;
      data_oe_o <= emu_n_s && active && writing && hold_n_s;
      bus_claim_ack_oe_o <= emu_n_s;
      machine_cycle_clock_oe_o <= emu_n_s;
    end
  end

  // acknowledge trails the float by one cycle, so lines are already off
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_claim_ack_n <= 1'b1;
      machine_cycle_clock_out <= 1'b0;
    end else begin
      bus_claim_ack_n <= !(next_in_hold && !select_oe_o && !addr_oe_o);
      machine_cycle_clock_out <= ~mc_phase;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  // all watched pins are registered, so each property sees settled values
  a_one_select: assert property (@(posedge clk_i) disable iff (reset_i)
    $countones({data_space_select_n, program_space_select_n, io_space_select_n}) >= 2)
    else $error("more than one space select low");
  a_strobe_match: assert property (@(posedge clk_i) disable iff (reset_i)
    !memory_access_strobe_n |-> io_space_select_n)
    else $error("memory strobe with io select");
  a_io_strobe: assert property (@(posedge clk_i) disable iff (reset_i)
    !io_access_strobe_n |-> !io_space_select_n)
    else $error("io strobe without io select");
  a_ack_floated: assert property (@(posedge clk_i) disable iff (reset_i)
    !bus_claim_ack_n |-> !select_oe_o && !strobe_oe_o && !addr_oe_o && !data_oe_o)
    else $error("acknowledge while bus driven");
  a_emu_float: assert property (@(posedge clk_i) disable iff (reset_i)
    !emu_n_s |=> !select_oe_o && !strobe_oe_o && !read_write_oe_o && !bus_claim_ack_oe_o)
    else $error("outputs driven under emulation float");
  a_rw_rest: assert property (@(posedge clk_i) disable iff (reset_i)
    !read_write_o |-> writing && (!memory_access_strobe_n || !io_access_strobe_n))
    else $error("write line low outside a write");
  a_clock_toggle: assert property (@(posedge clk_i) disable iff (reset_i)
    machine_cycle_clock_out |=> !machine_cycle_clock_out ##1 machine_cycle_clock_out)
    else $error("machine cycle clock not toggling");
  a_ready_wait: assert property (@(posedge clk_i) disable iff (reset_i)
    state == st_ready && mc_tick && !ready_s |=> state == st_ready)
    else $error("access ended while ready low");
  a_hold_float: assert property (@(posedge clk_i) disable iff (reset_i)
    state == st_hold |=> !addr_oe_o && !select_oe_o && !read_write_oe_o)
    else $error("bus driven in hold");
  a_data_float: assert property (@(posedge clk_i) disable iff (reset_i)
    !hold_n_s |=> !data_oe_o)
    else $error("data driven under hold request");
  a_select_strobe: assert property (@(posedge clk_i) disable iff (reset_i)
    !data_space_select_n || !program_space_select_n |-> !memory_access_strobe_n)
    else $error("memory select without memory strobe");
  a_strobe_float: assert property (@(posedge clk_i) disable iff (reset_i)
    state == st_hold |=> !strobe_oe_o)
    else $error("strobes driven in hold");
  a_ready_skipped: assert property (@(posedge clk_i) disable iff (reset_i)
    state == st_wait && mc_tick && wait_cnt == '0 && !use_ready |=> state == st_finish)
    else $error("ready looked at with too few wait states");
  a_ack_in_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    !bus_claim_ack_n |-> $past(state) == st_hold)
    else $error("acknowledge outside hold");
  a_select_addr: assert property (@(posedge clk_i) disable iff (reset_i)
    select_oe_o && !(data_space_select_n && program_space_select_n && io_space_select_n)
    |-> addr_oe_o)
    else $error("space select driven without address");
endmodule

// >>> tb/ebshc_ext_mem.sv
`timescale 1ns/1ps
`include "ebshc_params.svh"
// ****
// external memory and io device
// ****
module ebshc_ext_mem (
  // clock
  input wire logic clk_i,
  // bus as seen at the pins
  input wire logic sel_n_i,
  input wire logic write_i,
  input wire logic [`EBSHC_ADDR_W-1:0] addr_i,
  input wire logic [`EBSHC_DATA_W-1:0] wdata_i,
  input wire logic [3:0] stall_i,
  // answers
  output logic ready_o,
  output logic [`EBSHC_DATA_W-1:0] rdata_o
);
  logic [`EBSHC_DATA_W-1:0] mem [64];
  logic [3:0] cnt = 4'h0;
  initial ready_o = 1'b0;
  initial rdata_o = 16'h0000;
  // ready rises stall_i + 1 cycles into the access and drops once deselected
  always @(posedge clk_i) begin
    cnt <= sel_n_i ? 4'h0 : cnt + ((cnt != 4'hF) ? 4'h1 : 4'h0);
    ready_o <= !sel_n_i && (cnt >= stall_i);
    // a released bus flips its value every cycle instead of holding the last one
    rdata_o <= (!sel_n_i && !write_i) ? mem[addr_i] : ~rdata_o;
    if (!sel_n_i && write_i) mem[addr_i] <= wdata_i;
  end
endmodule

// >>> tb/test_ebshc_bus_ctrl.sv
`timescale 1ns/1ps
`include "ebshc_params.svh"
module test_ebshc_bus_ctrl;
  import ebshc_pkg::*;
  logic clk_i = 0, reset_i = 1, req_i = 0, req_write_i = 0, hold_req_n_i = 1;
  logic emulation_float_n = 1, done_o, ready_pin_i, addr_oe_o, data_oe_o;
  ebshc_space_type req_space_i = ebshc_space_data;
  logic [5:0] req_addr_i = 6'h00, addr_o;
  logic [15:0] req_wdata_i = 16'h0000, rdata_o, data_o, mem_q;
  logic [2:0] wait_states_i = 3'h0;
  logic [3:0] stall = 4'h0;
  logic ds_n, ps_n, is_n, sel_oe, ms_n, ios_n, st_oe, rw, rw_oe, ack_n, ack_oe, mck, mck_oe;
  int bad_count = 0, checks = 0, cyc = 0;
  wire [15:0] data_pin = data_oe_o ? data_o : mem_q;
  always #2 clk_i = ~clk_i;
  ebshc_bus_ctrl u_ebshc_bus_ctrl (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i),
    .req_space_i(req_space_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .wait_states_i(wait_states_i), .done_o(done_o),
    .rdata_o(rdata_o), .ready_pin_i(ready_pin_i), .hold_req_n_i(hold_req_n_i),
    .emulation_float_n(emulation_float_n), .data_pin_i(data_pin), .addr_o(addr_o),
    .addr_oe_o(addr_oe_o), .data_o(data_o), .data_oe_o(data_oe_o),
    .data_space_select_n(ds_n), .program_space_select_n(ps_n), .io_space_select_n(is_n),
    .select_oe_o(sel_oe), .memory_access_strobe_n(ms_n), .io_access_strobe_n(ios_n),
    .strobe_oe_o(st_oe), .read_write_o(rw), .read_write_oe_o(rw_oe),
    .bus_claim_ack_n(ack_n), .bus_claim_ack_oe_o(ack_oe),
    .machine_cycle_clock_out(mck), .machine_cycle_clock_oe_o(mck_oe));
  ebshc_ext_mem u_ebshc_ext_mem (.clk_i(clk_i), .sel_n_i(ds_n & ps_n & is_n),
    .write_i(~rw), .addr_i(addr_o), .wdata_i(data_pin), .stall_i(stall),
    .ready_o(ready_pin_i), .rdata_o(mem_q));
  // ****
  // shared tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one access; snap holds selects, strobes and direction mid-access
  task automatic access(input ebshc_space_type sp, input logic wr, input logic [5:0] a,
    input logic [15:0] wd, output int lat, output logic [5:0] snap);
    logic got;
    got = 0;
    snap = 6'h3F;
    lat = 0;
    req_space_i = sp;
    req_write_i = wr;
    req_addr_i = a;
    req_wdata_i = wd;
    req_i = 1;
    while (done_o !== 1'b1 && lat < 200) begin
      @(posedge clk_i) #1 lat++;
      if (!got && (ds_n & ps_n & is_n) === 1'b0) begin
        snap = {ds_n, ps_n, is_n, ms_n, ios_n, rw};
        got = 1;
      end
    end
    req_i = 0;
    // let an edge pass so the next request never meets this done pulse
    @(posedge clk_i) #1;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_spaces();
    logic [4:0] tbl [3] = '{5'b01101, 5'b10101, 5'b11010};
    logic [5:0] s;
    int l;
    logic m0;
    for (int i = 0; i < 3; i++) begin
      access(ebshc_space_type'(i), 1, 6'(i + 5), 16'hA50F ^ 16'(i), l, s);
      check(16'(s), {10'h000, tbl[i], 1'b0});
      check(16'(l <= 5 && l >= 4), 16'h0001);
      access(ebshc_space_type'(i), 0, 6'(i + 5), 16'h0000, l, s);
      check(16'(s), {10'h000, tbl[i], 1'b1});
      check(rdata_o, 16'hA50F ^ 16'(i));
    end
    // two edges keep the next request on a machine cycle boundary
    m0 = mck;
    @(posedge clk_i) #1 check({15'h0000, mck ^ m0}, 16'h0001);
    @(posedge clk_i) #1 check({15'h0000, mck ^ m0}, 16'h0000);
    check({15'h0000, mck_oe}, 16'h0001);
    $display("test spaces done");
  endtask
  task automatic t_ready();
    int l0, l1;
    logic [5:0] s;
    wait_states_i = 3'h1;
    stall = 4'hA;
    access(ebshc_space_data, 0, 6'h05, 16'h0000, l1, s);
    check(16'(l1 <= 7 && l1 >= 6), 16'h0001);
    wait_states_i = 3'h2;
    stall = 4'h0;
    access(ebshc_space_data, 0, 6'h05, 16'h0000, l0, s);
    stall = 4'hA;
    access(ebshc_space_data, 0, 6'h05, 16'h0000, l1, s);
    check(16'(l1 > l0), 16'h0001);
    check(rdata_o, 16'hA50F);
    stall = 4'h0;
    wait_states_i = 3'h0;
    $display("test ready done");
  endtask
  task automatic t_hold();
    int n;
    n = 0;
    hold_req_n_i = 0;
    while (ack_n !== 1'b0 && n < 20) @(posedge clk_i) #1 n++;
    check({sel_oe, st_oe, rw_oe, addr_oe_o, data_oe_o, ack_oe}, 16'h0001);
    check({15'h0000, ack_n}, 16'h0000);
    req_space_i = ebshc_space_io;
    req_write_i = 1;
    req_i = 1;
    n = 0;
    repeat (12) @(posedge clk_i) #1 n += (done_o === 1'b1);
    check(16'(n), 16'h0000);
    hold_req_n_i = 1;
    n = 0;
    while (done_o !== 1'b1 && n < 40) @(posedge clk_i) #1 n++;
    req_i = 0;
    check({15'h0000, done_o}, 16'h0001);
    check({15'h0000, ack_n}, 16'h0001);
    $display("test hold done");
  endtask
  task automatic t_float();
    emulation_float_n = 0;
    repeat (8) @(posedge clk_i);
    #1 check({sel_oe, st_oe, rw_oe, ack_oe, mck_oe, addr_oe_o, data_oe_o}, 16'h0000);
    emulation_float_n = 1;
    repeat (8) @(posedge clk_i);
    #1 check({ds_n, ps_n, is_n, ms_n, ios_n, rw}, 16'h003F);
    $display("test float done");
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    #1 reset_i = 0;
    repeat (5) @(posedge clk_i);
    #1 t_spaces();
    t_ready();
    t_hold();
    t_float();
    stop_test();
  end
endmodule
